/* File: psc_core.sv */
// Overview of operation
// RL1 - Lockout stops conversion, balancing, fault detection; logic and communication keep running.
// RL2 - Lockout entry keeps registers, zeroes balance control and sets the lockout flag.
// RL3 - Qualified power-on reset disables everything including host and vertical communication.
// RL4 - Supply above hysteresis for the delay releases reset with default registers.
// RL5 - Reset release sets the power-on-reset fault flag, held until host clears.
// RL6 - After reset the address is invalid and the assigned address reads zero.
// RL7 - Reset code written to reset register acts as a shortened power-on reset.
// RL8 - Reset command is honoured whatever address the device holds, even none.
// RL9 - Thermal shutdown turns off external 5 V regulator and the converter.
// RL10 - During thermal shutdown hold its flag, sleep request and sleep alert set.
// RL11 - Thermal shutdown disables the protection comparators.
// RL12 - Pin follows its drive bit; host sets bit then reads sense bit.
// RL13 - Auxiliary supply output follows its enable bit; code also gates it with reg5vEnable, off in reset, sleep and thermal shutdown.
// RL14 - Sleep entered when request bit set, left when cleared.
// RL15 - Sleep entry lets a running conversion finish, then pulses conversion done.
// RL16 - Sleep entry sets sleep alert and blocks all other fault and alert sources; thermal trip still sets its alert while asleep.
// RL17 - Host clears sleep alert by writing one then zero to save current.
// RL18 - Asleep: regulator off, converter off, protection comparators off.
// RL19 - Thermistor bias bits untouched by sleep; registers stay accessible while asleep.
// RL20 - Sleep exit restores regulator, comparators, converter after cold-start warm-up.
// RL21 - Sleep exit restores pre-sleep flags so pending fault or alert reasserts.
// RL22 - Flags clear by writing one; force bits take the written value.
// RL23 - Lockout and reset comparators are qualified by a continuous cycle count.
module psc_core #(
    parameter int SOFT_RST_CYC = psc_pkg::SOFT_RST_US * psc_pkg::CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic supplyLowCmp,
    input wire logic supplyPorCmp,
    input wire logic thermalTrip,
    input wire logic conversionBusy,
    input wire logic [psc_pkg::FLAG_W-1:0] faultEvt,
    input wire logic [psc_pkg::FLAG_W-1:0] alertEvt,
    input wire logic gpioIn,
    input wire logic ctrlWr,
    input wire logic [psc_pkg::CTL_W-1:0] ctrlData,
    input wire logic balanceWr,
    input wire logic [psc_pkg::BAL_W-1:0] balanceData,
    input wire logic faultWr,
    input wire logic [psc_pkg::FLAG_W-1:0] faultData,
    input wire logic alertWr,
    input wire logic [psc_pkg::FLAG_W-1:0] alertData,
    input wire logic addrWr,
    input wire logic [5:0] addrData,
    input wire logic resetWr,
    input wire logic [7:0] resetData,
    input wire logic statusClrWr,
    output logic commEnable,
    output logic adcEnable,
    output logic adcReady,
    output logic protectEnable,
    output logic reg5vEnable,
    output logic auxEnable,
    output logic [psc_pkg::BAL_W-1:0] balanceOut,
    output logic gpioOut,
    output logic gpioOe,
    output logic gpioSense,
    output logic [1:0] thermBias,
    output logic sleepReq,
    output logic sleepActive,
    output logic convDone,
    output logic [psc_pkg::FLAG_W-1:0] faultFlags,
    output logic [psc_pkg::FLAG_W-1:0] alertFlags,
    output logic faultPin,
    output logic alertPin,
    output logic lockoutFlag,
    output logic tsdFlag,
    output logic addressValid,
    output logic [5:0] address
);
    localparam logic [psc_pkg::CNT_W-1:0] SOFT_LOAD = (psc_pkg::CNT_W)'(SOFT_RST_CYC);

    typedef struct packed {
        psc_pkg::psc_state_t st;
        logic [psc_pkg::CNT_W-1:0] cnt;
        logic [psc_pkg::CTL_W-1:0] ctl;
        logic [psc_pkg::BAL_W-1:0] bal;
        logic [psc_pkg::FLAG_W-1:0] flt;
        logic [psc_pkg::FLAG_W-1:0] alr;
        logic [psc_pkg::FLAG_W-1:0] fltSave;
        logic [psc_pkg::FLAG_W-1:0] alrSave;
        logic lock;
        logic thermal_shutdown_flag;
        logic addrOk;
        logic [5:0] addr;
        logic done;
        logic sense;
    } psc_core_t;

    localparam psc_core_t CORE_RST = '0; // see RL6

    psc_core_t s_q;
    psc_core_t s_d;
    logic lowQ;
    logic porQ;
    logic awake;
    logic asleep;
    logic healthy;
    logic evOk;
    logic enterSlp;
    logic softHit;

    // Supply comparators pass through the delay qualifier
    psc_cmp_if cmp ();
    assign cmp.raw[psc_pkg::Q_LOW] = supplyLowCmp;
    assign cmp.raw[psc_pkg::Q_POR] = supplyPorCmp;
    assign lowQ = cmp.qual[psc_pkg::Q_LOW];
    assign porQ = cmp.qual[psc_pkg::Q_POR];

    psc_qual u_qual (
        .core_clk(core_clk),
        .resetn(resetn),
        .q(cmp)
    );

    // State decodes
    assign awake = (s_q.st == psc_pkg::ST_RUN) || (s_q.st == psc_pkg::ST_WARM);
    assign asleep = (s_q.st == psc_pkg::ST_DRAIN) || (s_q.st == psc_pkg::ST_SLEEP);
    assign healthy = !lowQ && !s_q.thermal_shutdown_flag;
    assign evOk = awake && healthy; // see RL1
    assign softHit = resetWr && (resetData == psc_pkg::RESET_CODE) && commEnable; // see RL8

    // Sequencer, host writes, then hardware sets so a set beats a clear
    always_comb begin
        s_d = s_q;
        enterSlp = 1'b0;
        s_d.done = 1'b0;
        s_d.sense = gpioIn;
        s_d.thermal_shutdown_flag = thermalTrip;
        case (s_q.st)
            psc_pkg::ST_RESET: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else begin
                    s_d.st = psc_pkg::ST_WARM; // see RL4
                    s_d.cnt = psc_pkg::WARM_LOAD;
                    s_d.flt[psc_pkg::FLT_POR] = 1'b1; // see RL5
                end
            end
            psc_pkg::ST_RUN, psc_pkg::ST_WARM: begin
                if (s_q.ctl[psc_pkg::CTL_SLEEP]) begin
                    enterSlp = 1'b1; // see RL14
                    s_d.fltSave = s_q.flt;
                    s_d.alrSave = s_q.alr;
                    // Only a running conversion needs draining
                    if (conversionBusy && s_q.st == psc_pkg::ST_RUN) begin
                        s_d.st = psc_pkg::ST_DRAIN; // see RL15
                    end else begin
                        s_d.st = psc_pkg::ST_SLEEP;
                    end
                end else if (s_q.st == psc_pkg::ST_WARM) begin
                    if (s_q.cnt == '0) begin
                        s_d.st = psc_pkg::ST_RUN; // see RL20
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
            end
            psc_pkg::ST_DRAIN: begin
                if (!conversionBusy) begin
                    s_d.st = psc_pkg::ST_SLEEP;
                    s_d.done = 1'b1; // see RL15
                end
            end
            psc_pkg::ST_SLEEP: begin
                if (!s_q.ctl[psc_pkg::CTL_SLEEP]) begin
                    s_d.st = psc_pkg::ST_WARM; // see RL14
                    s_d.cnt = psc_pkg::WARM_LOAD; // see RL20
                    s_d.flt = s_q.fltSave; // see RL21
                    s_d.alr = s_q.alrSave; // see RL21
                end
            end
            default: begin
                s_d = CORE_RST;
            end
        endcase
        // Registers stay writable in every state but reset
        if (commEnable) begin
            if (ctrlWr) begin
                s_d.ctl = ctrlData; // see RL19
            end
            if (balanceWr) begin
                s_d.bal = balanceData;
            end
            if (addrWr) begin
                s_d.addr = addrData;
                s_d.addrOk = (addrData >= psc_pkg::ADDR_MIN) && (addrData <= psc_pkg::ADDR_MAX);
            end
            if (statusClrWr) begin
                s_d.lock = 1'b0;
            end
            if (faultWr) begin
                s_d.flt = (s_d.flt & ~(faultData | psc_pkg::FORCE_M))
                    | (faultData & psc_pkg::FORCE_M); // see RL22
            end
            if (alertWr) begin
                s_d.alr = (s_d.alr & ~(alertData | psc_pkg::FORCE_M))
                    | (alertData & psc_pkg::FORCE_M); // see RL22
            end
        end
        // Detection is gated off in sleep, lockout and thermal shutdown
        if (evOk) begin
            s_d.flt = s_d.flt | (faultEvt & psc_pkg::FLT_EVT_M); // see RL16
            s_d.alr = s_d.alr | (alertEvt & psc_pkg::ALR_EVT_M);
        end
        if (enterSlp) begin
            s_d.alr[psc_pkg::ALR_SLEEP] = 1'b1; // see RL16
        end
        if (lowQ) begin
            s_d.bal = '0; // see RL2
            s_d.lock = 1'b1; // see RL2
        end
        // Re-asserted every cycle, so the host cannot wake it while hot
        if (thermalTrip && commEnable) begin
            s_d.ctl[psc_pkg::CTL_SLEEP] = 1'b1; // see RL10
            s_d.alr[psc_pkg::ALR_SLEEP] = 1'b1; // see RL10
            s_d.alr[psc_pkg::ALR_TSD] = 1'b1;
        end
        // Soft reset reuses the power-on path with a shorter hold
        if (softHit) begin
            s_d = CORE_RST; // see RL7
            s_d.cnt = SOFT_LOAD;
        end
        if (porQ) begin
            s_d = CORE_RST; // see RL3
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Power and enable outputs
    assign commEnable = s_q.st != psc_pkg::ST_RESET; // see RL3
    assign adcEnable = (awake || s_q.st == psc_pkg::ST_DRAIN) && healthy; // see RL9
    assign adcReady = (s_q.st == psc_pkg::ST_RUN) && healthy;
    assign protectEnable = awake && healthy; // see RL11
    assign reg5vEnable = commEnable && !asleep && !s_q.thermal_shutdown_flag; // see RL18
    assign auxEnable = reg5vEnable && s_q.ctl[psc_pkg::CTL_AUX]; // see RL13
    assign balanceOut = s_q.bal & {psc_pkg::BAL_W{commEnable && !lowQ}}; // see RL1

    // Open-drain pin: a one releases it so the pullup can be sensed
    assign gpioOut = 1'b0;
    assign gpioOe = !s_q.ctl[psc_pkg::CTL_GPIO]; // see RL12
    assign gpioSense = s_q.sense;
    assign thermBias = {s_q.ctl[psc_pkg::CTL_TS2], s_q.ctl[psc_pkg::CTL_TS1]};

    // Status outputs; in sleep only the sleep alert reaches the pins
    assign sleepReq = s_q.ctl[psc_pkg::CTL_SLEEP];
    assign sleepActive = asleep;
    assign convDone = s_q.done;
    assign faultFlags = s_q.flt;
    assign alertFlags = s_q.alr;
    assign faultPin = !asleep && (|s_q.flt); // see RL16
    assign alertPin = asleep ? s_q.alr[psc_pkg::ALR_SLEEP] : (|s_q.alr); // see RL21
    assign lockoutFlag = s_q.lock;
    assign tsdFlag = s_q.thermal_shutdown_flag;
    assign addressValid = s_q.addrOk;
    assign address = s_q.addr;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_lock_off;
        lowQ && commEnable |-> !adcEnable && !protectEnable && balanceOut == '0;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lockout left functions on"); // see RL1

    property p_lock_bal;
        lowQ && !porQ && !softHit |=> s_q.bal == '0 && lockoutFlag;
    endproperty
    a_lock_bal: assert property (p_lock_bal) else $error("lockout did not clear balance"); // see RL2

    property p_por_off;
        porQ |=> !commEnable && !reg5vEnable && !protectEnable && !adcEnable;
    endproperty
    a_por_off: assert property (p_por_off) else $error("reset left device active"); // see RL3

    property p_por_flag;
        $past(s_q.st) == psc_pkg::ST_RESET && commEnable
            |-> faultFlags[psc_pkg::FLT_POR] && !addressValid && address == '0;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("reset exit state wrong"); // see RL5

    property p_soft;
        softHit && !porQ |=> !commEnable && faultFlags == '0 ##1 !commEnable;
    endproperty
    a_soft: assert property (p_soft) else $error("reset code not honoured"); // see RL7

    property p_tsd_pwr;
        thermalTrip |=> !reg5vEnable && !adcEnable && !auxEnable;
    endproperty
    a_tsd_pwr: assert property (p_tsd_pwr) else $error("thermal trip left power on"); // see RL9

    property p_tsd_flags;
        thermalTrip && commEnable && !porQ && !softHit
            |=> tsdFlag && sleepReq && alertFlags[psc_pkg::ALR_SLEEP];
    endproperty
    a_tsd_flags: assert property (p_tsd_flags) else $error("thermal flags not set"); // see RL10

    property p_tsd_prot;
        thermalTrip |=> !protectEnable;
    endproperty
    a_tsd_prot: assert property (p_tsd_prot) else $error("comparators on in shutdown"); // see RL11

    property p_drain;
        s_q.st == psc_pkg::ST_DRAIN && !conversionBusy && !porQ && !softHit
            |=> convDone && sleepActive ##1 !convDone;
    endproperty
    a_drain: assert property (p_drain) else $error("conversion done not pulsed"); // see RL15

    property p_sleep_in;
        s_q.st == psc_pkg::ST_RUN && sleepReq && !conversionBusy && !porQ && !softHit
            |=> sleepActive && alertPin && !faultPin && !reg5vEnable && !protectEnable;
    endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep entry wrong"); // see RL16

    property p_sleep_out;
        s_q.st == psc_pkg::ST_SLEEP && !sleepReq && !porQ && !softHit && !faultWr
            |=> faultFlags == $past(s_q.fltSave) && (!healthy || protectEnable) && !adcReady;
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("sleep exit wrong"); // see RL21

    property p_flag_clr;
        alertWr && alertData[psc_pkg::ALR_OT] && commEnable && !evOk && !porQ
            |=> !alertFlags[psc_pkg::ALR_OT];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("write one did not clear"); // see RL22

    property p_gpio;
        ctrlWr && commEnable && !porQ && !softHit && !thermalTrip
            |=> gpioOe == !$past(ctrlData[psc_pkg::CTL_GPIO]);
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin drive wrong"); // see RL12

    c_sleep_cycle: cover property (sleepActive ##1 !sleepActive);
    c_drain: cover property (s_q.st == psc_pkg::ST_DRAIN ##1 convDone);
    c_soft: cover property (softHit ##1 !commEnable);
    c_lock: cover property (lowQ && commEnable);
endmodule

/* File: psc_pkg.sv */
package psc_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 40;
    localparam int LOCKOUT_DELAY_NS = 10000;
    localparam int LOCKOUT_CYC = (LOCKOUT_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int WARM_US = 100;
    localparam int WARM_CYC = WARM_US * CLK_MHZ;
    localparam int SOFT_RST_US = 300;
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] LOCK_LAST = (CNT_W)'(LOCKOUT_CYC - 1);
    localparam logic [CNT_W-1:0] WARM_LOAD = (CNT_W)'(WARM_CYC);

    // Comparator qualifier lanes
    localparam int Q_W = 2;
    localparam int Q_LOW = 0;
    localparam int Q_POR = 1;

    // Host codes and address range
    localparam logic [7:0] RESET_CODE = 8'ha5;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [5:0] ADDR_MAX = 6'h3e;

    // Flag layouts
    localparam int FLAG_W = 4;
    localparam int FLT_POR = 0;
    localparam int FLT_CUV = 1;
    localparam int FLT_COV = 2;
    localparam int ALR_SLEEP = 0;
    localparam int ALR_TSD = 1;
    localparam int ALR_OT = 2;
    localparam logic [FLAG_W-1:0] FORCE_M = 4'h8;
    localparam logic [FLAG_W-1:0] FLT_EVT_M = 4'h6;
    localparam logic [FLAG_W-1:0] ALR_EVT_M = 4'h4;

    // Pin and power control fields
    localparam int CTL_W = 5;
    localparam int CTL_SLEEP = 0;
    localparam int CTL_GPIO = 1;
    localparam int CTL_AUX = 2;
    localparam int CTL_TS1 = 3;
    localparam int CTL_TS2 = 4;
    localparam int BAL_W = 6;

    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_WARM = 3'h1,
        ST_RUN = 3'h3,
        ST_DRAIN = 3'h7,
        ST_SLEEP = 3'h5
    } psc_state_t;
endpackage

/* File: psc_cmp_if.sv */
interface psc_cmp_if;
    logic [psc_pkg::Q_W-1:0] raw;
    logic [psc_pkg::Q_W-1:0] qual;
    modport qual_side (input raw, output qual);
    modport user_side (output raw, input qual);
endinterface

/* File: psc_qual.sv */
module psc_qual (
    input wire logic core_clk,
    input wire logic resetn,
    psc_cmp_if.qual_side q
);
    typedef struct packed {
        logic [psc_pkg::Q_W-1:0][psc_pkg::CNT_W-1:0] cnt;
        logic [psc_pkg::Q_W-1:0] qual;
    } psc_qual_t;

    psc_qual_t s_q;
    psc_qual_t s_d;
    logic [psc_pkg::CNT_W-1:0] cntNxt [psc_pkg::Q_W];
    logic [psc_pkg::Q_W-1:0] qualNxt;

    // Level flips only after the raw level differs for the whole delay
    for (genvar i = 0; i < psc_pkg::Q_W; i++) begin : g_lane
        logic diff;
        logic full;
        assign diff = q.raw[i] ^ s_q.qual[i];
        assign full = s_q.cnt[i] == psc_pkg::LOCK_LAST;
        assign cntNxt[i] = (diff && !full) ? s_q.cnt[i] + 1'b1 : '0; // see RL23
        assign qualNxt[i] = (diff && full) ? q.raw[i] : s_q.qual[i]; // see RL23

        property p_qual_hold;
            @(posedge core_clk) disable iff (!resetn)
            (s_q.qual[i] != $past(s_q.qual[i])) |-> $past(s_q.cnt[i]) == psc_pkg::LOCK_LAST;
        endproperty
        a_qual_hold: assert property (p_qual_hold) else $error("qualifier flipped early"); // see RL23
    end

    // Gather lanes into the next state
    always_comb begin
        s_d.qual = qualNxt;
        for (int k = 0; k < psc_pkg::Q_W; k++) begin
            s_d.cnt[k] = cntNxt[k];
        end
    end

    // Glitches shorter than the delay never reach the core
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q.qual = s_q.qual;
endmodule

/* File: psc_core_tb.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Short soft-reset period keeps the run brief
    localparam int SRST = 20;

    logic core_clk, resetn, supplyLowCmp, supplyPorCmp, thermalTrip, conversionBusy, gpioIn;
    logic ctrlWr, balanceWr, faultWr, alertWr, addrWr, resetWr, statusClrWr;
    logic [4:0] ctrlData;
    logic [5:0] balanceData, addrData, balanceOut, address;
    logic [3:0] faultEvt, alertEvt, faultData, alertData, faultFlags, alertFlags;
    logic [7:0] resetData, r;
    logic [1:0] thermBias;
    logic commEnable, adcEnable, adcReady, protectEnable, reg5vEnable, auxEnable, gpioOut;
    logic gpioOe, gpioSense, sleepReq, sleepActive, convDone, faultPin, alertPin;
    logic lockoutFlag, tsdFlag, addressValid;
    int error_cnt = 0;
    int n_compared = 0;
    int seed = 32'h8a5b;
    int mFault, mAlert, mAddr, mCtrl, mBal, n, k;
    int addrTab[5] = '{0, 1, 62, 63, 21};

    psc_core #(.SOFT_RST_CYC(SRST)) u_psc_core (.core_clk, .resetn, .supplyLowCmp,
        .supplyPorCmp, .thermalTrip, .conversionBusy, .faultEvt, .alertEvt, .gpioIn, .ctrlWr,
        .ctrlData, .balanceWr, .balanceData, .faultWr, .faultData, .alertWr, .alertData,
        .addrWr, .addrData, .resetWr, .resetData, .statusClrWr, .commEnable, .adcEnable,
        .adcReady, .protectEnable, .reg5vEnable, .auxEnable, .balanceOut, .gpioOut, .gpioOe,
        .gpioSense, .thermBias, .sleepReq, .sleepActive, .convDone, .faultFlags, .alertFlags,
        .faultPin, .alertPin, .lockoutFlag, .tsdFlag, .addressValid, .address);

    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge core_clk);
    endtask

    // One host write; strobe sampled at the second rising edge
    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge core_clk);
        ctrlData <= d[4:0];
        balanceData <= d[5:0];
        faultData <= d[3:0];
        alertData <= d[3:0];
        addrData <= d[5:0];
        resetData <= d;
        ctrlWr <= (sel == 0);
        balanceWr <= (sel == 1);
        faultWr <= (sel == 2);
        alertWr <= (sel == 3);
        addrWr <= (sel == 4);
        resetWr <= (sel == 5);
        statusClrWr <= (sel == 6);
        @(posedge core_clk);
        {ctrlWr, balanceWr, faultWr, alertWr, addrWr, resetWr, statusClrWr} <= 7'h00;
        @(negedge core_clk);
    endtask

    task automatic evt(input logic [3:0] f, input logic [3:0] a);
        @(posedge core_clk);
        faultEvt <= f;
        alertEvt <= a;
        @(posedge core_clk);
        faultEvt <= 4'h0;
        alertEvt <= 4'h0;
        cyc(2);
    endtask

    // Bounded wait; a hang ends the run as a mismatch
    task automatic wait_hi(input int comm, input int bound, output int cnt);
        cnt = 0;
        while ((comm ? commEnable : adcReady) !== 1'b1) begin
            if (cnt >= bound) begin
                error_cnt++;
                finish_test();
            end
            cnt++;
            @(negedge core_clk);
        end
    endtask

    // Register model against the design, valid while awake
    task automatic chk_model;
        chk("faultFlags", mFault, faultFlags);
        chk("alertFlags", mAlert, alertFlags);
        chk("faultPin", mFault != 0, faultPin);
        chk("address", mAddr, address);
        chk("addressValid", mAddr >= 1 && mAddr <= 62, addressValid);
        chk("gpioOe", !mCtrl[1], gpioOe);
        chk("gpioOut", 0, gpioOut);
        chk("auxEnable", mCtrl[2], auxEnable);
        chk("thermBias", mCtrl[4:3], thermBias);
        chk("sleepReq", mCtrl[0], sleepReq);
        chk("balanceOut", mBal, balanceOut);
    endtask

    initial begin
        resetn = 1'b0;
        {supplyLowCmp, supplyPorCmp, thermalTrip, conversionBusy, gpioIn} = 5'h00;
        {ctrlWr, balanceWr, faultWr, alertWr, addrWr, resetWr, statusClrWr} = 7'h00;
        {ctrlData, balanceData, faultData, alertData, addrData, resetData} = 33'h0;
        {faultEvt, alertEvt} = 8'h00;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        {mFault, mAlert, mAddr, mCtrl, mBal} = {32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        cyc(3);
        chk("commEnable", 1, commEnable);
        chk_model();
        wait_hi(0, 4100, n);
        chk("warmUp", 1, n >= 3990);
        foreach (addrTab[i]) begin
            wr(4, addrTab[i]);
            mAddr = addrTab[i];
            chk_model();
        end
        // Random control and balance patterns, sleep bit kept clear
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            wr(0, r & 8'h1e);
            wr(1, r & 8'h3f);
            mCtrl = r & 8'h1e;
            mBal = r & 8'h3f;
            chk_model();
            @(posedge core_clk);
            gpioIn <= r[k];
            cyc(2);
            chk("gpioSense", r[k], gpioSense);
        end
        wr(2, 8'h08);
        mFault = 9;
        chk_model();
        wr(2, 8'h00);
        mFault = 1;
        chk_model();
        wr(2, 8'h01);
        evt(4'h4, 4'h4);
        wr(2, 8'h02);
        {mFault, mAlert} = {32'h4, 32'h4};
        chk_model();
        wr(3, 8'h04);
        mAlert = 0;
        chk_model();
        // Sleep entry while a conversion is still running
        @(posedge core_clk);
        conversionBusy <= 1'b1;
        wr(0, 8'h19);
        cyc(2);
        chk("sleepActive", 1, sleepActive);
        chk("convDone", 0, convDone);
        @(posedge core_clk);
        conversionBusy <= 1'b0;
        n = 0;
        repeat (6) begin
            @(negedge core_clk);
            n += convDone;
        end
        chk("convDonePulses", 1, n);
        chk("reg5vSleep", 0, reg5vEnable);
        chk("adcSleep", 0, adcEnable);
        chk("protectSleep", 0, protectEnable);
        chk("alertSleep", 1, alertFlags[0]);
        chk("alertPinSleep", 1, alertPin);
        chk("faultPinSleep", 0, faultPin);
        chk("biasKept", 3, thermBias);
        evt(4'h2, 4'h4);
        chk("faultBlocked", 4, faultFlags);
        chk("alertBlocked", 0, alertFlags[2]);
        wr(3, 8'h05);
        wr(3, 8'h00);
        chk("alertPinClr", 0, alertPin);
        wr(4, 8'h21);
        chk("addrSleep", 8'h21, address);
        wr(0, 8'h00);
        cyc(1);
        chk("reg5vWake", 1, reg5vEnable);
        chk("protectWake", 1, protectEnable);
        chk("adcCold", 0, adcReady);
        chk("faultRestore", 4, faultFlags);
        chk("faultPinWake", 1, faultPin);
        wait_hi(0, 4100, n);
        chk("warmAgain", 1, n >= 3990);
        wr(2, 8'h04);
        wr(3, 8'h07);
        {mFault, mAlert, mAddr, mCtrl} = {32'h0, 32'h0, 32'h21, 32'h0};
        chk_model();
        // Lockout: one edge short, then long enough
        wr(1, 8'h2a);
        @(posedge core_clk);
        supplyLowCmp <= 1'b1;
        repeat (399) @(posedge core_clk);
        supplyLowCmp <= 1'b0;
        cyc(2);
        chk("balanceShort", 8'h2a, balanceOut);
        chk("lockShort", 0, lockoutFlag);
        @(posedge core_clk);
        supplyLowCmp <= 1'b1;
        repeat (402) @(posedge core_clk);
        cyc(1);
        chk("balanceLock", 0, balanceOut);
        chk("lockFlag", 1, lockoutFlag);
        chk("adcLock", 0, adcEnable);
        chk("protectLock", 0, protectEnable);
        chk("commLock", 1, commEnable);
        wr(4, 8'h05);
        mAddr = 5;
        mBal = 0;
        @(posedge core_clk);
        supplyLowCmp <= 1'b0;
        repeat (405) @(posedge core_clk);
        wr(6, 8'h00);
        chk("lockClr", 0, lockoutFlag);
        chk_model();
        // Thermal shutdown
        @(posedge core_clk);
        thermalTrip <= 1'b1;
        cyc(3);
        chk("tsdFlag", 1, tsdFlag);
        chk("tsdSleepReq", 1, sleepReq);
        chk("tsdAlerts", 3, alertFlags[1:0]);
        chk("tsdReg5v", 0, reg5vEnable);
        chk("tsdAdc", 0, adcEnable);
        chk("tsdProtect", 0, protectEnable);
        @(posedge core_clk);
        thermalTrip <= 1'b0;
        cyc(2);
        chk("tsdCool", 0, tsdFlag);
        wr(0, 8'h00);
        wr(3, 8'h07);
        chk_model();
        // Soft reset from an unaddressed device
        wr(4, 8'h00);
        wr(5, 8'h5a);
        chk("wrongCode", 1, commEnable);
        wr(5, 8'ha5);
        wait_hi(1, 200, n);
        chk("softLow", SRST + 1, n);
        {mFault, mAlert, mAddr, mCtrl, mBal} = {32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        cyc(2);
        chk_model();
        // Power-on reset comparator
        wr(4, 8'h09);
        @(posedge core_clk);
        supplyPorCmp <= 1'b1;
        repeat (402) @(posedge core_clk);
        cyc(1);
        chk("porComm", 0, commEnable);
        chk("porReg5v", 0, reg5vEnable);
        wr(4, 8'h07);
        @(posedge core_clk);
        supplyPorCmp <= 1'b0;
        wait_hi(1, 1000, n);
        chk("porHold", 1, n >= 398);
        cyc(2);
        chk_model();
        finish_test();
    end
endmodule
